/* verification/cgs_host.sv */
`default_nettype none
module cgs_host (
  // Clock
  input  wire logic       clk,
  // Two-wire link, data released means high
  output var  logic       scl,
  output var  logic       sda,
  input  wire logic       sda_in,
  // Byte results
  output var  logic [7:0] res,
  output var  logic       res_vld
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {scl, sda, res, res_vld} = 11'h600;
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_c;
    sda = 0;
    w(6);
    scl = 0;
    w(2);
  endtask
  task automatic stop_c;
    sda = 0;
    w(8);
    scl = 1;
    w(6);
    sda = 1;
    w(6);
  endtask
  // Low phase is 10 cycles so the slave's synchronised ack lands well before the rise.
  task automatic byte_c(input logic [7:0] b, input logic rd, input logic ak);
    logic [7:0] v;
    logic       a;
    for (int i = 7; i >= -1; i--) begin
      sda = i < 0 ? (rd ? ak : 1'b1) : (rd | b[i]);
      w(8);
      scl = 1;
      w(6);
      if (i >= 0) v[i] = sda_in;
      else a = !sda_in;
      scl = 0;
      w(2);
    end
    res = rd ? v : {7'h0, a};
    res_vld = 1;
    w(1);
    res_vld = 0;
  endtask
endmodule
`default_nettype wire

/* verification/cgs_props.sv */
`default_nettype none
module cgs_props (
  // Clock, reset and link
  input wire logic       REF_CLK,
  input wire logic       RST,
  input wire logic       SERIAL_CLOCK_PIN,
  input wire logic       SERIAL_DATA_PIN_O,
  input wire logic       SERIAL_DATA_PIN_OE,
  // Pins and decoded fields
  input wire logic       POWER_DOWN_INPUT_N,
  input wire logic       CPU_CLOCK_HALT_INPUT_N,
  input wire logic [1:0] MODE,
  input wire logic [2:0] SPREAD_WIDTH_SELECT,
  input wire logic [1:0] PERIPHERAL_CLOCK_48M,
  input wire logic [1:0] PERIPHERAL_CLOCK_EN,
  input wire logic [1:0] CPU_CLOCK_RUN,
  input wire logic [6:0] PCI_CLOCK_EN,
  input wire logic [3:0] REFERENCE_CLOCK_OUTPUT_EN,
  input wire logic [7:0] PLL_MULTIPLIER,
  input wire logic [5:0] PLL_DIVIDER
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_pin_open_drain: assert property (!SERIAL_DATA_PIN_O)
    else $error("data pin driven high");
  a_oe_clock_low: assert property ($changed(SERIAL_DATA_PIN_OE) |-> !SERIAL_CLOCK_PIN)
    else $error("data moved with clock high");
  a_oe_holds_bit: assert property ($rose(SERIAL_DATA_PIN_OE) |-> SERIAL_DATA_PIN_OE [*8])
    else $error("pull-down cut short");
  a_no_initiate: assert property (SERIAL_CLOCK_PIN [*8] |-> !$rose(SERIAL_DATA_PIN_OE))
    else $error("device drove an idle bus");
  a_reset_values: assert property ($fell(RST) |-> MODE == 2'h0
    && SPREAD_WIDTH_SELECT == 3'h7 && PERIPHERAL_CLOCK_48M == 2'h3
    && PLL_MULTIPLIER == 8'h00 && PLL_DIVIDER == 6'h00) else $error("bad power-up value");
  // Stored fields may only move while a byte is being clocked in.
  a_cfg_on_clock: assert property ($changed({MODE, SPREAD_WIDTH_SELECT,
    PLL_MULTIPLIER, PLL_DIVIDER}) |-> SERIAL_CLOCK_PIN || $past(SERIAL_CLOCK_PIN, 2))
    else $error("field changed without bus activity");
  a_power_down_off: assert property (!POWER_DOWN_INPUT_N [*8] |-> PCI_CLOCK_EN == 7'h00
    && CPU_CLOCK_RUN == 2'h0 && REFERENCE_CLOCK_OUTPUT_EN == 4'h0
    && PERIPHERAL_CLOCK_EN == 2'h0) else $error("clock left running in power-down");
  a_halt_stops_cpu: assert property (!CPU_CLOCK_HALT_INPUT_N [*8] |-> !CPU_CLOCK_RUN[1])
    else $error("second cpu clock ignores halt");
  c_ack: cover property ($rose(SERIAL_DATA_PIN_OE));
  c_power_down: cover property (!POWER_DOWN_INPUT_N [*8]);
  c_tristate: cover property (MODE == 2'h3);
endmodule
bind cgs_smbus_slave cgs_props u_props (.*);
`default_nettype wire

/* verification/tb_clock_gen_smbus_config_slave.sv */
`include "cgs_map.vh"
`default_nettype none
module tb_clock_gen_smbus_config_slave;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst = 1, pdn_n = 1, halt_n = 1, o, oe, mfb, um, ud;
  wire        scl, sda_h, rv;
  wire  [7:0] rb;
  logic [1:0] mode, p48, pen, run;
  logic [2:0] sws;
  logic [6:0] pci;
  logic [5:0] sdr, div;
  logic [3:0] refen;
  logic [7:0] mul, d [0:10], exp_q [$];
  int         num_errors = 0, comparisons = 0, cyc = 0, seed = 5;
  logic [7:0] rstv [0:9] = '{`CGS_RST_FUNC, `CGS_RST_CPU, `CGS_RST_PCI, `CGS_RST_SDRAM,
    `CGS_RST_RSVD, `CGS_RST_REF, `CGS_RST_MULT, `CGS_RST_DIV, `CGS_RST_FEN, 8'h00};
  logic [7:0] msk [0:9] = '{`CGS_MASK_FUNC, `CGS_MASK_CPU, `CGS_MASK_PCI, `CGS_MASK_SDRAM,
    `CGS_MASK_RSVD, `CGS_MASK_REF, `CGS_MASK_MULT, `CGS_MASK_DIV, `CGS_MASK_FEN, 8'h00};
  wire        sda_w = sda_h & ~(oe & ~o);
  cgs_host host (.clk(clk), .scl(scl), .sda(sda_h), .sda_in(sda_w), .res(rb), .res_vld(rv));
  cgs_smbus_slave uut (.REF_CLK(clk), .RST(rst), .SERIAL_CLOCK_PIN(scl),
    .SERIAL_DATA_PIN_I(sda_w), .SERIAL_DATA_PIN_O(o), .SERIAL_DATA_PIN_OE(oe),
    .POWER_DOWN_INPUT_N(pdn_n), .CPU_CLOCK_HALT_INPUT_N(halt_n), .MODE(mode),
    .SPREAD_WIDTH_SELECT(sws), .PERIPHERAL_CLOCK_48M(p48), .PERIPHERAL_CLOCK_EN(pen),
    .MEMORY_FEEDBACK_CLOCK_EN(mfb), .CPU_CLOCK_RUN(run), .PCI_CLOCK_EN(pci),
    .SDRAM_CLOCK_EN(sdr), .REFERENCE_CLOCK_OUTPUT_EN(refen), .PLL_MULTIPLIER(mul),
    .PLL_DIVIDER(div), .PLL_USE_MULTIPLIER(um), .PLL_USE_DIVIDER(ud));
  always #2 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (rv) check(rb, exp_q.pop_front());
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end
  // Writes for reads record 01 when the slave acknowledged the byte.
  task automatic put(input logic [7:0] b, input logic rd, input logic ak, input logic [7:0] e);
    exp_q.push_back(e);
    host.byte_c(b, rd, ak);
  endtask
  task automatic write(input logic [7:0] a, input int n, input logic ok);
    host.start_c;
    put(a, 0, 0, {7'h0, ok});
    for (int k = 0; k < n + 2; k++)
      put(k < 2 ? 8'($random(seed)) : d[k-2], 0, 0, {7'h0, ok && k < 12});
    host.stop_c;
  endtask
  task automatic readback(input logic masked);
    host.start_c;
    put(`CGS_ADDR_RD, 0, 0, 8'h01);
    for (int k = 0; k < 10; k++)
      put(8'hFF, 1, k == 9, masked ? d[k] & msk[k] : rstv[k]);
    host.stop_c;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    repeat (8) @(posedge clk);
    readback(0);
    foreach (d[k]) d[k] = 8'($random(seed));
    d[1] = d[1] & 8'hFA | 8'h01;
    write(`CGS_ADDR_WR, 11, 1);
    readback(1);
    for (int m = 0; m < 4; m++) begin
      d[0] = {d[0][7:2], 2'(m)};
      write(`CGS_ADDR_WR, 1, 1);
      check({6'h0, mode}, 8'(m));
      check({5'h0, sws}, {5'h0, d[0][6:4]});
      check({6'h0, p48}, {6'h0, d[0][3:2]});
    end
    d[0] = ~d[0];
    write(8'hA4, 2, 0);
    check({6'h0, mode}, 8'h03);
    pdn_n = 0;
    repeat (10) @(posedge clk);
    check({1'b0, pci}, 8'h00);
    check({2'h0, sdr}, {2'h0, d[3][5:0]});
    #1 pdn_n = 1;
    halt_n = 0;
    repeat (10) @(posedge clk);
    check({6'h0, run}, 8'h01);
    check({1'b0, pci}, {1'b0, d[2][6:0]});
    check({pen, mfb, refen, 1'h0}, {d[1][7:6], d[1][3], d[5][5:4], d[5][1:0], 1'h0});
    check(mul, d[6]);
    check({2'h0, div}, {2'h0, d[7][5:0]});
    check({6'h0, um, ud}, {6'h0, d[8][7:6]});
    report_and_stop;
  end
endmodule
`default_nettype wire

/* verilog/cgs_map.vh */
// Functional notes
// - Device is a slave only: accepts writes and reads, never starts a transfer.
// - Link runs standard mode, at most one hundred kilobits per second.
// - Data changes only while clock is low, stable while clock high.
// - Data falling with clock high is start; data rising with clock high is stop.
// - Every unit is an eight-bit byte, MSB first, followed by acknowledge.
// - On write address the device acknowledges up to ten data bytes.
// - Other addresses and conditions are ignored; stored values stay unchanged.
// - After acknowledging read address the device drives register data at once.
// - During a read the device waits for host acknowledge after each byte.
// - A read runs until stop; on stop the device ends transmission; the code also ends it when the host does not acknowledge a byte.
// - Write carries command and count bytes, acknowledged and discarded.
// - Registers load defaults only at true power-up, not on power-down pin.
// - Function bits 1:0 select tri-state, spread, test or non-spread mode.
// - Function bits 3 and 2 select 48 or 24 MHz per peripheral output.
// - Function bits 6:4 spread width select default all ones; bit 7 reserved zero.
// - Clock enable bits run output when one, stop when zero; default one.
// - CPU enable bit 2 zero makes first CPU clock ignore the halt input.
// - Multiplier is eight bits; divider six bits in next byte; both default zero.
// - Frequency-enable bit 7 selects programmed multiplier, bit 6 divider.
`ifndef CGS_MAP_VH
`define CGS_MAP_VH
`define CGS_ADDR_WR      8'hD2
`define CGS_ADDR_RD      8'hD3
`define CGS_NUM_REGS     4'h9
`define CGS_MAX_DATA     4'hA
`define CGS_HDR_BYTES    2'h2
`define CGS_REG_FUNC     4'h0
`define CGS_REG_CPU      4'h1
`define CGS_REG_PCI      4'h2
`define CGS_REG_SDRAM    4'h3
`define CGS_REG_RSVD     4'h4
`define CGS_REG_REF      4'h5
`define CGS_REG_MULT     4'h6
`define CGS_REG_DIV      4'h7
`define CGS_REG_FEN      4'h8
`define CGS_RST_FUNC     8'h7C
`define CGS_RST_CPU      8'hCF
`define CGS_RST_PCI      8'h7F
`define CGS_RST_SDRAM    8'hFF
`define CGS_RST_RSVD     8'h00
`define CGS_RST_REF      8'h33
`define CGS_RST_MULT     8'h00
`define CGS_RST_DIV      8'h00
`define CGS_RST_FEN      8'h00
`define CGS_MASK_FUNC    8'h7F
`define CGS_MASK_CPU     8'hCF
`define CGS_MASK_PCI     8'h7F
`define CGS_MASK_SDRAM   8'hFF
`define CGS_MASK_RSVD    8'h00
`define CGS_MASK_REF     8'h33
`define CGS_MASK_MULT    8'hFF
`define CGS_MASK_DIV     8'h3F
`define CGS_MASK_FEN     8'hC0
`define CGS_BIT_CPU_HALT 2
`define CGS_BIT_NEN      7
`define CGS_BIT_REN      6
`define CGS_LINK_KBPS    100
`endif

/* verilog/cgs_smbus_slave.v */
`include "cgs_map.vh"
`default_nettype none
module cgs_smbus_slave (
  // Clock and power-up reset
  input  wire       REF_CLK,
  input  wire       RST,
  // Two-wire link
  input  wire       SERIAL_CLOCK_PIN,
  input  wire       SERIAL_DATA_PIN_I,
  output reg        SERIAL_DATA_PIN_O,
  output reg        SERIAL_DATA_PIN_OE,
  // Power pins
  input  wire       POWER_DOWN_INPUT_N,
  input  wire       CPU_CLOCK_HALT_INPUT_N,
  // Decoded configuration
  output reg  [1:0] MODE,
  output reg  [2:0] SPREAD_WIDTH_SELECT,
  output reg  [1:0] PERIPHERAL_CLOCK_48M,
  output reg  [1:0] PERIPHERAL_CLOCK_EN,
  output reg        MEMORY_FEEDBACK_CLOCK_EN,
  output reg  [1:0] CPU_CLOCK_RUN,
  output reg  [6:0] PCI_CLOCK_EN,
  output reg  [5:0] SDRAM_CLOCK_EN,
  output reg  [3:0] REFERENCE_CLOCK_OUTPUT_EN,
  output reg  [7:0] PLL_MULTIPLIER,
  output reg  [5:0] PLL_DIVIDER,
  output reg        PLL_USE_MULTIPLIER,
  output reg        PLL_USE_DIVIDER
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_WACK = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_RDAT = 3'd4;
  localparam ST_RACK = 3'd5;

  wire       scl_s;
  wire       sda_s;
  reg        scl_q;
  reg        sda_q;
  reg  [2:0] st_q;
  reg  [2:0] bit_q;
  reg  [7:0] sh_q;
  reg        rd_q;
  reg  [1:0] hdr_q;
  reg  [3:0] cnt_q;
  reg  [3:0] ptr_q;
  reg  [7:0] regs_q [0:8];
  reg        drive_low_q;
  reg        got_q;

  // Sampling every pin at the system clock resolves a standard-mode link with wide margin.
  // The power-down pin is deliberately not part of any reset: values survive it.
  cgs_sync u_scl (.clk(REF_CLK), .rst(RST), .din(SERIAL_CLOCK_PIN), .dout(scl_s));
  cgs_sync u_sda (.clk(REF_CLK), .rst(RST), .din(SERIAL_DATA_PIN_I), .dout(sda_s));
  wire       halt_s;
  wire       pdn_s;
  cgs_sync u_hlt (.clk(REF_CLK), .rst(RST), .din(CPU_CLOCK_HALT_INPUT_N), .dout(halt_s));
  cgs_sync u_pdn (.clk(REF_CLK), .rst(RST), .din(POWER_DOWN_INPUT_N), .dout(pdn_s));

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire [7:0] byte_in = {sh_q[6:0], sda_s};

  function [7:0] wmask;
    input [3:0] idx;
    begin
      case (idx)
        `CGS_REG_FUNC:  wmask = `CGS_MASK_FUNC;
        `CGS_REG_CPU:   wmask = `CGS_MASK_CPU;
        `CGS_REG_PCI:   wmask = `CGS_MASK_PCI;
        `CGS_REG_SDRAM: wmask = `CGS_MASK_SDRAM;
        `CGS_REG_REF:   wmask = `CGS_MASK_REF;
        `CGS_REG_MULT:  wmask = `CGS_MASK_MULT;
        `CGS_REG_DIV:   wmask = `CGS_MASK_DIV;
        `CGS_REG_FEN:   wmask = `CGS_MASK_FEN;
        default:        wmask = `CGS_MASK_RSVD;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = (ptr_q < `CGS_NUM_REGS) ? regs_q[ptr_q] : 8'h00;

  // Only the true power-up reset loads defaults.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      regs_q[0] <= `CGS_RST_FUNC;
      regs_q[1] <= `CGS_RST_CPU;
      regs_q[2] <= `CGS_RST_PCI;
      regs_q[3] <= `CGS_RST_SDRAM;
      regs_q[4] <= `CGS_RST_RSVD;
      regs_q[5] <= `CGS_RST_REF;
      regs_q[6] <= `CGS_RST_MULT;
      regs_q[7] <= `CGS_RST_DIV;
      regs_q[8] <= `CGS_RST_FEN;
    end else if (st_q == ST_WDAT && scl_rise && bit_q == 3'd7 && hdr_q == `CGS_HDR_BYTES
                 && cnt_q < `CGS_MAX_DATA && ptr_q < `CGS_NUM_REGS) begin
      regs_q[ptr_q] <= byte_in & wmask(ptr_q);
    end
  end

  // Protocol engine: slave only, sampling on clock rise, driving on clock fall.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      st_q        <= ST_IDLE;
      bit_q       <= 3'd0;
      sh_q        <= 8'h00;
      rd_q        <= 1'b0;
      hdr_q       <= 2'd0;
      cnt_q       <= 4'd0;
      ptr_q       <= 4'd0;
      drive_low_q <= 1'b0;
      got_q       <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (start_c) begin
        st_q        <= ST_ADDR;
        bit_q       <= 3'd0;
        got_q       <= 1'b0;
        drive_low_q <= 1'b0;
      end else if (stop_c) begin
        st_q        <= ST_IDLE;
        drive_low_q <= 1'b0;
      end else begin
        case (st_q)
          ST_ADDR, ST_WDAT: begin
            // The clock fall that closes a start must not be taken for the end of a byte.
            if (scl_rise) begin
              sh_q  <= byte_in;
              bit_q <= bit_q + 3'd1;
              got_q <= (bit_q == 3'd7);
            end else if (scl_fall) begin
              got_q <= 1'b0;
            end
            if (scl_fall && got_q && st_q == ST_ADDR && {sh_q[7:1], 1'b0} == `CGS_ADDR_WR) begin
              rd_q        <= sh_q[0];
              hdr_q       <= 2'd0;
              cnt_q       <= 4'd0;
              ptr_q       <= 4'd0;
              drive_low_q <= 1'b1;
              st_q        <= ST_WACK;
            end else if (scl_fall && got_q && st_q == ST_ADDR) begin
              st_q <= ST_IDLE;
            end else if (scl_fall && got_q) begin
              if (hdr_q != `CGS_HDR_BYTES) begin
                hdr_q <= hdr_q + 2'd1;
              end else if (cnt_q < `CGS_MAX_DATA) begin
                cnt_q <= cnt_q + 4'd1;
                ptr_q <= ptr_q + 4'd1;
              end
              drive_low_q <= (hdr_q != `CGS_HDR_BYTES) || (cnt_q < `CGS_MAX_DATA);
              st_q        <= ST_WACK;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              if (rd_q) begin
                drive_low_q <= ~rd_byte[7];
                sh_q        <= {rd_byte[6:0], 1'b0};
                bit_q       <= 3'd1;
                st_q        <= ST_RDAT;
              end else begin
                drive_low_q <= 1'b0;
                st_q        <= ST_WDAT;
              end
            end
          end
          ST_RDAT: begin
            if (scl_fall) begin
              if (bit_q == 3'd0) begin
                drive_low_q <= 1'b0;
                st_q        <= ST_RACK;
                ptr_q       <= ptr_q + 4'd1;
              end else begin
                drive_low_q <= ~sh_q[7];
                sh_q        <= {sh_q[6:0], 1'b0};
                bit_q       <= bit_q + 3'd1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st_q <= sda_s ? ST_IDLE : ST_WACK;
            end
          end
          default: begin
            st_q        <= ST_IDLE;
            drive_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Outputs are registered; power-down stops the peripheral, CPU, PCI and reference clock enables, not SDRAM or memory feedback, without touching the bytes.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SERIAL_DATA_PIN_O         <= 1'b0;
      SERIAL_DATA_PIN_OE        <= 1'b0;
      MODE                      <= 2'b00;
      SPREAD_WIDTH_SELECT       <= 3'b111;
      PERIPHERAL_CLOCK_48M      <= 2'b11;
      PERIPHERAL_CLOCK_EN       <= 2'b00;
      MEMORY_FEEDBACK_CLOCK_EN  <= 1'b0;
      CPU_CLOCK_RUN             <= 2'b00;
      PCI_CLOCK_EN              <= 7'h00;
      SDRAM_CLOCK_EN            <= 6'h00;
      REFERENCE_CLOCK_OUTPUT_EN <= 4'h0;
      PLL_MULTIPLIER            <= 8'h00;
      PLL_DIVIDER               <= 6'h00;
      PLL_USE_MULTIPLIER        <= 1'b0;
      PLL_USE_DIVIDER           <= 1'b0;
    end else begin
      SERIAL_DATA_PIN_O         <= 1'b0;
      SERIAL_DATA_PIN_OE        <= drive_low_q;
      MODE                      <= regs_q[0][1:0];
      SPREAD_WIDTH_SELECT       <= regs_q[0][6:4];
      PERIPHERAL_CLOCK_48M      <= regs_q[0][3:2];
      PERIPHERAL_CLOCK_EN       <= regs_q[1][7:6] & {2{pdn_s}};
      MEMORY_FEEDBACK_CLOCK_EN  <= regs_q[1][3];
      CPU_CLOCK_RUN[0]          <= pdn_s & regs_q[1][0]
                                   & (halt_s | ~regs_q[1][`CGS_BIT_CPU_HALT]);
      CPU_CLOCK_RUN[1]          <= pdn_s & regs_q[1][1] & halt_s;
      PCI_CLOCK_EN              <= regs_q[2][6:0] & {7{pdn_s}};
      SDRAM_CLOCK_EN            <= regs_q[3][5:0];
      REFERENCE_CLOCK_OUTPUT_EN <= {regs_q[5][5:4], regs_q[5][1:0]} & {4{pdn_s}};
      PLL_MULTIPLIER            <= regs_q[6];
      PLL_DIVIDER               <= regs_q[7][5:0];
      PLL_USE_MULTIPLIER        <= regs_q[8][`CGS_BIT_NEN];
      PLL_USE_DIVIDER           <= regs_q[8][`CGS_BIT_REN];
    end
  end
endmodule
`default_nettype wire

/* verilog/cgs_sync.v */
`default_nettype none
// Three-stage synchroniser; a change is taken once stages two and three agree.
module cgs_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Signal
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire
